// ---- hw/sc_pkg.sv ----
// Constants shared by the manager end, the controller end and the bench.
// Assumes a 100 MHz system clock and a strobe-clocked manager byte bus.
`default_nettype none
package sc_pkg;
  localparam int unsigned MGR_W = 8;
  localparam int unsigned INSTR_W = 6;
  localparam int unsigned CDATA_W = 32;
  localparam int unsigned PORTS = 8;
  localparam int unsigned ARB_W = 7;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned FS_CNT_W = 16;
  localparam int unsigned FRAME_SYNC_PERIOD = 64;

  // Manager command byte layout
  localparam int unsigned OP_HI = 7;
  localparam int unsigned OP_LO = 6;
  localparam int unsigned CLR_BIT = 5;
  localparam int unsigned CLAIM_BIT = 4;
  localparam int unsigned SEL_HI = 2;
  localparam int unsigned SEL_LO = 0;
  localparam logic [1:0] OP_CTRL = 2'h0;
  localparam logic [1:0] OP_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  // Data-group read selector
  localparam logic [2:0] RSEL_FRAMES = 3'h4;

  localparam logic [INSTR_W-1:0] INSTR_NOP = 6'h00;
  localparam logic [MGR_W-1:0] BUS_IDLE = 8'hff;

  // Manager strobe timing in system clocks
  localparam logic [7:0] STROBE_LOW_CYCLES = 8'h02;
  localparam logic [7:0] STROBE_HIGH_CYCLES = 8'h08;

  typedef enum logic [1:0] {XF_IDLE, XF_WR, XF_RD, XF_RD_CAP} xfer_e;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH} host_e;
endpackage
`default_nettype wire

// ---- hw/mgr_if.sv ----
// Manager byte bus between the setup processor end and the controller.
// The bench joins both ends through this interface.
`timescale 1ns/1ps
`default_nettype none
interface mgr_if;
  logic [sc_pkg::MGR_W-1:0] host_o;
  logic host_oe;
  logic [sc_pkg::MGR_W-1:0] dev_o;
  logic dev_oe;
  logic rw;
  logic sel;
  logic strobe;
  logic [sc_pkg::MGR_W-1:0] bus;

  // Pulled-up wire: undriven bus floats high
  assign bus = dev_oe ? dev_o : (host_oe ? host_o : sc_pkg::BUS_IDLE);

  modport mgr (output host_o, output host_oe, output rw, output sel,
    output strobe, input bus);
  modport dev (output dev_o, output dev_oe, input rw, input sel,
    input strobe, input bus);
endinterface
`default_nettype wire

// ---- hw/sig_sync.sv ----
// Three-stage synchroniser with agreement filter.
// Assumes d is a level from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module sig_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Only stages two and three vote, stage one stays isolated
    for (int i = 0; i < W; i++)
    begin
      if (st_reg.s2[i] == st_reg.s3[i])
      begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule
`default_nettype wire

// ---- hw/mgr_host_end.sv ----
// Setup processor end of the manager bus.
// Makes the strobe from its own clock; one access at a time from the user.
`timescale 1ns/1ps
`default_nettype none
module mgr_host_end #(
  parameter logic [7:0] LOW_CYCLES = sc_pkg::STROBE_LOW_CYCLES,
  parameter logic [7:0] HIGH_CYCLES = sc_pkg::STROBE_HIGH_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  mgr_if.mgr m,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_sel,
  input wire logic [sc_pkg::MGR_W-1:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sc_pkg::MGR_W-1:0] rsp_data
);
  typedef struct packed {
    sc_pkg::host_e st;
    logic [7:0] cnt;
    logic rw;
    logic sel;
    logic [sc_pkg::MGR_W-1:0] dout;
    logic doe;
    logic strobe;
    logic rsp_v;
    logic [sc_pkg::MGR_W-1:0] rsp_d;
  } host_s;

  host_s h_reg;
  host_s h_next;

  always_comb
  begin
    h_next = h_reg;
    h_next.rsp_v = 1'b0;
    unique case (h_reg.st)
      sc_pkg::H_IDLE:
      begin
        h_next.doe = 1'b0;
        h_next.rw = 1'b1;
        if (req_valid)
        begin
          h_next.rw = ~req_write;
          h_next.sel = req_sel;
          h_next.dout = req_data;
          h_next.doe = req_write;
          h_next.st = sc_pkg::H_SETUP;
        end
      end
      sc_pkg::H_SETUP:
      begin
        h_next.strobe = 1'b0;
        h_next.cnt = 8'h01;
        h_next.st = sc_pkg::H_LOW;
      end
      sc_pkg::H_LOW:
      begin
        h_next.cnt = h_reg.cnt + 8'h01;
        if (h_reg.cnt >= LOW_CYCLES)
        begin
          // Read data has settled by the end of the low phase
          if (h_reg.rw)
          begin
            h_next.rsp_d = m.bus;
            h_next.rsp_v = 1'b1;
          end
          h_next.strobe = 1'b1;
          h_next.cnt = 8'h01;
          h_next.st = sc_pkg::H_HIGH;
        end
      end
      sc_pkg::H_HIGH:
      begin
        // Long high phase lets the controller's synchroniser settle
        h_next.cnt = h_reg.cnt + 8'h01;
        if (h_reg.cnt >= HIGH_CYCLES)
        begin
          h_next.doe = 1'b0;
          h_next.rw = 1'b1;
          h_next.st = sc_pkg::H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      h_reg <= '{st: sc_pkg::H_IDLE, cnt: 8'h00, rw: 1'b1, sel: 1'b0,
        dout: 8'h00, doe: 1'b0, strobe: 1'b1, rsp_v: 1'b0, rsp_d: 8'h00};
    end
    else
    begin
      h_reg <= h_next;
    end
  end

  assign req_ready = (h_reg.st == sc_pkg::H_IDLE);
  assign rsp_valid = h_reg.rsp_v;
  assign rsp_data = h_reg.rsp_d;
  assign m.host_o = h_reg.dout;
  assign m.host_oe = h_reg.doe;
  assign m.rw = h_reg.rw;
  assign m.sel = h_reg.sel;
  assign m.strobe = h_reg.strobe;
endmodule
`default_nettype wire

// ---- hw/switch_ctrl_end.sv ----
// Controller end: manager register groups, reset chain, memory-side
// instruction and control data buses, frame inputs and arbitration lines.
// Assumes reset is the reset input pin and clk the system clock.
`timescale 1ns/1ps
`default_nettype none
module switch_ctrl_end #(
  parameter int unsigned FRAME_SYNC_PERIOD = sc_pkg::FRAME_SYNC_PERIOD
) (
  input wire logic clk,
  input wire logic reset,
  mgr_if.dev mgr,
  input wire logic master_mode,
  input wire logic multi_mode,
  output logic reset_chain_out,
  output logic [sc_pkg::INSTR_W-1:0] mem_instr_bus,
  output logic [sc_pkg::CDATA_W-1:0] ctrl_data_o,
  output logic ctrl_data_oe,
  input wire logic [sc_pkg::CDATA_W-1:0] ctrl_data_i,
  input wire logic header_check_error_n,
  output logic frame_sync_out,
  input wire logic [sc_pkg::PORTS-1:0] port_frame_inputs,
  output logic [sc_pkg::ARB_W-1:0] arbitration_lines_o,
  output logic [sc_pkg::ARB_W-1:0] arbitration_lines_oe,
  output logic [sc_pkg::PORTS-1:0] port_load_ready
);
  ////////////////////////////////////////////////////////////////////////
  // Strobe domain: write capture

  typedef struct packed {
    logic [sc_pkg::MGR_W-1:0] cmd;
    logic [sc_pkg::CDATA_W-1:0] data;
    logic tgl;
  } mgr_s;

  mgr_s m_reg;
  mgr_s m_next;

  always_comb
  begin
    m_next = m_reg;
    if (!mgr.rw)
    begin
      if (mgr.sel)
      begin
        m_next.data = {m_reg.data[sc_pkg::CDATA_W-sc_pkg::MGR_W-1:0], mgr.bus};
      end
      else
      begin
        m_next.cmd = mgr.bus;
        m_next.tgl = ~m_reg.tgl;
      end
    end
  end

  always_ff @(posedge mgr.strobe or posedge reset)
  begin
    if (reset)
    begin
      m_reg <= '0;
    end
    else
    begin
      m_reg <= m_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossings into the system clock

  logic tgl_s;
  logic [sc_pkg::PORTS-1:0] frame_s;

  // Command byte and data word are quasi-static once the toggle lands
  sig_sync #(.W(1)) u_tgl_sync (
    .clk(clk),
    .reset(reset),
    .d(m_reg.tgl),
    .q(tgl_s)
  );

  sig_sync #(.W(sc_pkg::PORTS)) u_frame_sync (
    .clk(clk),
    .reset(reset),
    .d(port_frame_inputs),
    .q(frame_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // System clock domain

  typedef struct packed {
    logic chain_out;
    sc_pkg::xfer_e state;
    logic tgl_seen;
    logic [sc_pkg::INSTR_W-1:0] instr;
    logic [sc_pkg::CDATA_W-1:0] dout;
    logic doe;
    logic [sc_pkg::CDATA_W-1:0] rd_word;
    logic [sc_pkg::SEL_HI:sc_pkg::SEL_LO] rd_sel;
    logic [sc_pkg::PORTS-1:0] frame_prev;
    logic [sc_pkg::PORTS-1:0] frame_seen;
    logic hdr_err;
    logic [sc_pkg::ARB_W-1:0] claim;
    logic [sc_pkg::FS_CNT_W-1:0] fs_cnt;
    logic fs_out;
  } sys_s;

  sys_s s_reg;
  sys_s s_next;
  logic [1:0] op;
  logic new_cmd;
  logic [sc_pkg::PORTS-1:0] frame_rise;
  logic [sc_pkg::PORTS-1:0] frame_mask;

  assign op = m_reg.cmd[sc_pkg::OP_HI:sc_pkg::OP_LO];
  assign new_cmd = (tgl_s != s_reg.tgl_seen)
    && (s_reg.state == sc_pkg::XF_IDLE);
  // Pins 1-7 are arbitration lines in multi mode; pin 0 stays a frame
  assign frame_mask = multi_mode ? {{sc_pkg::ARB_W{1'b0}}, 1'b1}
    : {sc_pkg::PORTS{1'b1}};
  assign frame_rise = frame_s & ~s_reg.frame_prev & frame_mask;

  always_comb
  begin
    s_next = s_reg;
    s_next.instr = sc_pkg::INSTR_NOP;
    s_next.doe = 1'b0;
    s_next.frame_prev = frame_s;
    s_next.state = sc_pkg::XF_IDLE;
    unique case (s_reg.state)
      sc_pkg::XF_IDLE:
      begin
      end
      sc_pkg::XF_WR:
      begin
        s_next.doe = 1'b1;
      end
      sc_pkg::XF_RD:
      begin
        s_next.state = sc_pkg::XF_RD_CAP;
      end
      sc_pkg::XF_RD_CAP:
      begin
        s_next.rd_word = ctrl_data_i;
      end
    endcase
    if (new_cmd)
    begin
      s_next.tgl_seen = tgl_s;
      unique case (op)
        sc_pkg::OP_CTRL:
        begin
          s_next.rd_sel = m_reg.cmd[sc_pkg::SEL_HI:sc_pkg::SEL_LO];
          if (m_reg.cmd[sc_pkg::CLR_BIT])
          begin
            s_next.frame_seen = '0;
            s_next.hdr_err = 1'b0;
          end
          if (m_reg.cmd[sc_pkg::CLAIM_BIT])
          begin
            s_next.claim = m_reg.data[sc_pkg::ARB_W-1:0];
          end
        end
        sc_pkg::OP_START:
        begin
          s_next.chain_out = 1'b0;
        end
        sc_pkg::OP_WRITE:
        begin
          s_next.instr = m_reg.cmd[sc_pkg::INSTR_W-1:0];
          s_next.dout = m_reg.data;
          s_next.state = sc_pkg::XF_WR;
        end
        sc_pkg::OP_READ:
        begin
          s_next.instr = m_reg.cmd[sc_pkg::INSTR_W-1:0];
          s_next.state = sc_pkg::XF_RD;
        end
      endcase
    end
    // Sets come after clears so a coincident event is kept
    s_next.frame_seen = s_next.frame_seen | frame_rise;
    if (!header_check_error_n)
    begin
      s_next.hdr_err = 1'b1;
    end
    s_next.fs_out = 1'b0;
    if (master_mode && multi_mode)
    begin
      if (s_reg.fs_cnt == sc_pkg::FS_CNT_W'(FRAME_SYNC_PERIOD - 1))
      begin
        s_next.fs_cnt = '0;
        s_next.fs_out = 1'b1;
      end
      else
      begin
        s_next.fs_cnt = s_reg.fs_cnt + 1'b1;
      end
    end
    else
    begin
      s_next.fs_cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.chain_out <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Manager read path: asynchronous by nature of the bus

  logic [sc_pkg::MGR_W-1:0] status_byte;
  logic [sc_pkg::MGR_W-1:0] data_byte;

  assign status_byte = {s_reg.chain_out, s_reg.hdr_err,
    (s_reg.state != sc_pkg::XF_IDLE), multi_mode, master_mode, s_reg.rd_sel};

  always_comb
  begin
    data_byte = s_reg.frame_seen;
    if (s_reg.rd_sel != sc_pkg::RSEL_FRAMES)
    begin
      data_byte = s_reg.rd_word[{s_reg.rd_sel[1:0], 3'h0} +: sc_pkg::MGR_W];
    end
  end

  assign mgr.dev_o = mgr.sel ? data_byte : status_byte;
  assign mgr.dev_oe = ~mgr.strobe & mgr.rw;

  assign reset_chain_out = s_reg.chain_out;
  assign mem_instr_bus = s_reg.instr;
  assign ctrl_data_o = s_reg.dout;
  assign ctrl_data_oe = s_reg.doe;
  assign frame_sync_out = s_reg.fs_out;
  // Open-drain claim: pull low only in multi mode
  assign arbitration_lines_o = '0;
  assign arbitration_lines_oe = multi_mode ? s_reg.claim : '0;
  assign port_load_ready = s_reg.frame_seen;
endmodule
`default_nettype wire

// ---- test/sc_properties.sv ----
// Checker on the manager bus wires and the controller's memory-side pins.
// Assumes one system clock; the host end makes the strobe from it.
`timescale 1ns/1ps
`default_nettype none
module sc_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic rw,
  input wire logic sel,
  input wire logic strobe,
  input wire logic host_oe,
  input wire logic [7:0] host_o,
  input wire logic dev_oe,
  input wire logic [7:0] dev_o,
  input wire logic [7:0] bus,
  input wire logic reset_chain_out,
  input wire logic [5:0] mem_instr_bus,
  input wire logic ctrl_data_oe,
  input wire logic frame_sync_out
);
  logic start_seen_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // Set one cycle before the strobe rise on purpose: the chain can only drop after capture
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      start_seen_reg <= 1'b0;
    else if (!strobe && !rw && !sel && host_o[7:6] == sc_pkg::OP_START)
      start_seen_reg <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_read_enable: assert property (
    dev_oe == (!strobe && rw))
    else $error("controller bus enable wrong");
  chk_bus_owner: assert property (
    dev_oe |-> bus == dev_o && !host_oe)
    else $error("manager bus not carried by controller");
  chk_strobe_pulse: assert property (
    $fell(strobe) |=> !strobe ##1 strobe)
    else $error("strobe low phase wrong");
  chk_write_hold: assert property ($rose(strobe) && !rw |->
    host_oe && $stable(host_o) && $stable(sel))
    else $error("write byte not held at strobe rise");
  chk_chain_on: assert property (disable iff (1'b0)
    reset |-> reset_chain_out)
    else $error("chain output low during reset");
  chk_chain_hold: assert property ($fell(reset_chain_out) |->
    start_seen_reg)
    else $error("chain output dropped without start");
  chk_instr_single: assert property (mem_instr_bus != 6'h00 |=>
    mem_instr_bus == 6'h00)
    else $error("instruction held too long");
  chk_data_lag: assert property (ctrl_data_oe |->
    $past(mem_instr_bus) != 6'h00 && mem_instr_bus == 6'h00)
    else $error("control data not one cycle after instruction");
  chk_sync_pulse: assert property (
    frame_sync_out |=> !frame_sync_out)
    else $error("frame sync wider than one cycle");
  cover property ($rose(strobe) && !rw);
  cover property ($fell(reset_chain_out));
  cover property (ctrl_data_oe);
  cover property (dev_oe);
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench: host end and controller end joined by mgr_if.
// Assumes the host end makes the strobe from clk with default timing.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned FS_P = 4;
  localparam logic [5:0] RD_INSTR = 6'h2a;
  logic clk, reset, req_valid, req_write, req_sel, req_ready, rsp_valid;
  logic master_mode, multi_mode, reset_chain_out, ctrl_data_oe;
  logic header_check_error_n, frame_sync_out;
  logic [7:0] req_data, rsp_data, rd_byte, mask, port_frame_inputs;
  logic [7:0] port_load_ready;
  logic [6:0] arbitration_lines_o, arbitration_lines_oe;
  logic [5:0] mem_instr_bus, got_instr, instr;
  logic [31:0] ctrl_data_o, ctrl_data_i, got_word, word_in;
  logic [7:0] b [4];
  int errors = 0, num_checks = 0, cycles = 0, fs_count = 0, n0;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  mgr_if mi();
  mgr_host_end mgr_host_end_inst (.m(mi), .*);
  switch_ctrl_end #(.FRAME_SYNC_PERIOD(FS_P)) switch_ctrl_end_inst (
    .mgr(mi), .*);
  sc_properties sc_properties_inst (.rw(mi.rw), .sel(mi.sel),
    .strobe(mi.strobe), .host_oe(mi.host_oe), .host_o(mi.host_o),
    .dev_oe(mi.dev_oe), .dev_o(mi.dev_o), .bus(mi.bus), .*);
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    // Read word stands only in the cycle after the read instruction
    ctrl_data_i <= (mem_instr_bus == RD_INSTR) ? word_in : ~word_in;
    if (mem_instr_bus != 6'h00)
      got_instr <= mem_instr_bus;
    if (ctrl_data_oe)
      got_word <= ctrl_data_o;
    if (frame_sync_out)
      fs_count <= fs_count + 1;
    if (cycles == 8000)
    begin
      errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pack(input logic [7:0] v [4]);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  function automatic logic [7:0] stat(input logic c, h, mu, ma);
    return {c, h, 1'b0, mu, ma, 3'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read waits for the answer; a write returns once taken
  task automatic op(input logic wr, s, input logic [7:0] d);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_sel <= s;
    req_data <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    while (!wr && rsp_valid !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    rd_byte = rsp_data;
    chk("handshake", 32'(n < 50), 32'h1);
  endtask

  // Command crosses a synchroniser, so give it time to act
  task automatic wcmd(input logic [7:0] d);
    op(1'b1, 1'b0, d);
    repeat (14) @(negedge clk);
  endtask

  task automatic wr_word;
    for (int i = 0; i < 4; i++)
    begin
      b[i] = 8'($urandom);
      op(1'b1, 1'b1, b[i]);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b0;
    {req_valid, req_write, req_sel, req_data} = '0;
    {master_mode, multi_mode, port_frame_inputs} = '0;
    header_check_error_n = 1'b1;
    void'($urandom(32'hb436));
    word_in = $urandom;
    // A clean rising edge starts every asynchronous reset branch
    #1 reset = 1'b1;
    repeat (8) @(posedge clk);
    chk("chain in reset", reset_chain_out, 1);
    reset <= 1'b0;
    op(1'b0, 1'b0, 8'h00);
    chk("status", rd_byte, stat(1, 0, 0, 0));
    for (int k = 0; k < 4; k++)
    begin
      wr_word();
      instr = (k == 0) ? 6'h01 : (k == 1) ? 6'h3f : 6'($urandom_range(62, 1));
      wcmd({sc_pkg::OP_WRITE, instr});
      chk("instr", got_instr, instr);
      chk("word out", got_word, pack(b));
    end
    wcmd({sc_pkg::OP_READ, RD_INSTR});
    chk("read instr", got_instr, RD_INSTR);
    for (int k = 0; k < 4; k++)
    begin
      wcmd({5'h00, 3'(k)});
      op(1'b0, 1'b1, 8'h00);
      chk("word in", rd_byte, word_in[8*k +: 8]);
    end
    @(posedge clk);
    mask = 8'($urandom) | 8'h81;
    port_frame_inputs <= mask;
    wcmd(8'h04);
    chk("load ready", port_load_ready, mask);
    op(1'b0, 1'b1, 8'h00);
    chk("frame flags", rd_byte, mask);
    @(posedge clk);
    port_frame_inputs <= 8'h00;
    header_check_error_n <= 1'b0;
    @(posedge clk);
    header_check_error_n <= 1'b1;
    wcmd(8'h24);
    chk("flags cleared", port_load_ready, 0);
    @(posedge clk);
    header_check_error_n <= 1'b0;
    @(posedge clk);
    header_check_error_n <= 1'b1;
    master_mode <= 1'b1;
    multi_mode <= 1'b1;
    port_frame_inputs <= 8'hff;
    wr_word();
    wcmd(8'h10);
    chk("multi ready", port_load_ready, 8'h01);
    chk("claim", arbitration_lines_oe, b[3][6:0]);
    chk("pull low", arbitration_lines_o, 0);
    n0 = fs_count;
    repeat (40) @(negedge clk);
    chk("sync count", fs_count - n0, 40 / FS_P);
    chk("chain held", reset_chain_out, 1);
    wcmd({sc_pkg::OP_START, 6'h00});
    chk("chain free", reset_chain_out, 0);
    op(1'b0, 1'b0, 8'h00);
    chk("status", rd_byte, stat(0, 1, 1, 1));
    @(posedge clk);
    reset <= 1'b1;
    #1;
    chk("async chain", reset_chain_out, 1);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    op(1'b0, 1'b0, 8'h00);
    chk("status", rd_byte, stat(1, 0, 1, 1));
    wrap_up();
  end
endmodule
`default_nettype wire
